// [core/bmp_pkg.sv]
// Notes on behaviour
// [RULE1] The data RAM size register is a fixed 32-bit read-only value giving the RAM size in bytes: 0x00004000, 0x00008000 or 0x00010000.
// [RULE2] Bits 19 to 11 of the user program base register are software read/write storage for the flash user base.
// [RULE3] Bits 10 to 0 of the user program base register always read zero, giving 2 KB steps.
// [RULE4] Bits 31 to 20 of the user program base register read zero and ignore writes.
// [RULE5] Any reset forces the user program base register to zero.
// [RULE6] Software keeps the written base at or below the reported program flash size.
// [RULE7] Writes to the data RAM size register are ignored and reads always give the fixed size.
package bmp_pkg;
    // Register byte offsets
    localparam logic [7:0] BMP_OFF_DRAM_SIZE = 8'h00;
    localparam logic [7:0] BMP_OFF_UPB = 8'h04;
    // Legal RAM size encodings
    localparam logic [31:0] BMP_RAM_16K = 32'h0000_4000;
    localparam logic [31:0] BMP_RAM_32K = 32'h0000_8000;
    localparam logic [31:0] BMP_RAM_64K = 32'h0001_0000;
    // Writable base field position
    localparam int BMP_UPB_LSB = 11;
    localparam int BMP_UPB_MSB = 19;
    localparam logic [8:0] BMP_UPB_RESET = 9'h000;
    localparam logic [31:0] BMP_UPB_MASK = 32'h000F_F800;
    // AHB encodings
    localparam logic [1:0] BMP_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] BMP_HTRANS_SEQ = 2'h3;
    localparam logic [2:0] BMP_HSIZE_WORD = 3'h2;
endpackage

// [core/bmp_regs.sv]
// Added by the designer: the AHB-Lite register port and the address map.
module bmp_regs
    import bmp_pkg::*;
#(
    parameter logic [31:0] RAM_SIZE = BMP_RAM_64K // Fixed RAM size of this device
) (
    input wire logic clk, // System clock, 40 MHz
    input wire logic rstn, // Async reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write when high
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready in
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Ready from the first edge after reset, low in reset
    output logic hresp, // Always OKAY
    output logic [31:0] user_flash_base_address // Current user base
);
    // Bus timing, for whoever integrates this block
    // Zero-wait slave: hreadyout stays high once out of reset
    // Address phase taken on a rising edge with hsel, hready and NONSEQ or SEQ
    // Write data taken on the following edge, in the data phase
    // Read data loaded on the address edge, stands for the whole data phase
    // Outside a read data phase hrdata is zero, never stale data
    // Only haddr[7:0] decoded; the slot repeats across a wider select window
    // Unmapped offsets read zero and swallow writes with an OKAY answer
    // Hsize not checked: every transfer treated as one whole word
    // Narrow writes would land as full words; masters must not issue them
    // Hresp tied to OKAY; there is no error path to raise
    // Storage
    // Only nine flops hold software state, the base field
    // Rest of the base word built from constants, so it cannot drift
    // Size word is a parameter; no flop stores it, no reset can disturb it
    // Trade-off: size fixed per build rather than per fuse setting
    // Base against flash size left to software on purpose
    // Hardware clamping would silently move a partition software believes set
    // Hazards
    // Read right after a base write must see the new field: forward path
    // Reset asynchronous on entry, released by the next clock edge
    // First edge after release still shows hreadyout low; masters wait on it
    // Base output mirrors the stored field from the edge the write lands
    // Limitations
    // No wait states, so no back-pressure hook exists for slower storage
    // Bursts accepted beat by beat; SEQ is treated exactly like NONSEQ
    // No byte strobes: partial updates of the base field are impossible
    // Checks below watch only what this block drives
    // Three checks run through reset itself and carry no disable
    // All others are disabled while rstn is low
    // Address phase capture
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr_q;
    logic [8:0] upb_field;
    logic [31:0] next_hrdata;

    // Offset match, shared by both phases
    function automatic logic bmp_is_off(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // Full base word from the field; everything else reads zero
    function automatic logic [31:0] bmp_base_word(input logic [8:0] f);
        return {12'h000, f, 11'h000}; // RULE3 RULE4
    endfunction

    // Transfer accepted when selected, ready and not idle or busy
    wire logic active = hsel && hready &&
        (htrans == BMP_HTRANS_NONSEQ || htrans == BMP_HTRANS_SEQ);
    // Captured offset decode, used in the data phase
    wire logic hit_upb = bmp_is_off(addr_q, BMP_OFF_UPB);
    wire logic hit_dram = bmp_is_off(addr_q, BMP_OFF_DRAM_SIZE);
    wire logic upb_we = wr_pend && hit_upb;
    // Only bits 19..11 land; the size register has no write path
    wire logic [8:0] next_upb = upb_we ? hwdata[BMP_UPB_MSB:BMP_UPB_LSB] : upb_field; // RULE2 RULE7
    // Compose full base word; low and high bits tie to zero
    wire logic [31:0] upb_word = bmp_base_word(upb_field); // RULE3 RULE4
    // Data-phase view of what the captured offset must return
    wire logic [31:0] rd_word = hit_dram ? RAM_SIZE :
        (hit_upb ? upb_word : 32'h0000_0000); // RULE1

    // Live decode for the read prepared in the address phase
    wire logic live_dram = bmp_is_off(haddr[7:0], BMP_OFF_DRAM_SIZE);
    wire logic live_upb = bmp_is_off(haddr[7:0], BMP_OFF_UPB);
    // Read data prepared at the address phase so it stands in the data phase;
    // next_upb forwards a write still in its data phase to a following read
    wire logic [31:0] next_rd_word = live_dram ? RAM_SIZE :
        (live_upb ? bmp_base_word(next_upb) : 32'h0000_0000);
    assign next_hrdata = (active && !hwrite) ? next_rd_word : 32'h0000_0000;

    // Address phase register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_pend <= active && hwrite;
            rd_pend <= active && !hwrite;
            addr_q <= haddr[7:0];
        end
    end

    // Base storage, cleared by any reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            upb_field <= BMP_UPB_RESET; // RULE5
        end else begin
            upb_field <= next_upb;
        end
    end

    // Registered outputs; zero-wait slave
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            user_flash_base_address <= 32'h0000_0000;
        end else begin
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            user_flash_base_address <= bmp_base_word(next_upb);
        end
    end

    // Checks
    // Size read returns the build constant
    property p_size_fixed;
        @(posedge clk) disable iff (!rstn)
        rd_pend && hit_dram |-> hrdata == RAM_SIZE;
    endproperty
    a_size_fixed: assert property (p_size_fixed) else $error("size read wrong"); // RULE1

    // Written field shows on the base output one edge later
    property p_upb_write;
        @(posedge clk) disable iff (!rstn)
        upb_we |=> user_flash_base_address[19:11] == $past(hwdata[19:11]);
    endproperty
    a_upb_write: assert property (p_upb_write) else $error("base write lost"); // RULE2

    // Low bits of the base never set
    property p_low_zero;
        @(posedge clk) disable iff (!rstn)
        1'b1 |-> user_flash_base_address[10:0] == 11'h000;
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("low bits nonzero"); // RULE3

    // Unimplemented top bits read zero
    property p_high_zero;
        @(posedge clk) disable iff (!rstn)
        rd_pend && hit_upb |-> hrdata[31:20] == 12'h000;
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("high bits nonzero"); // RULE4

    // Base moves only on a base write
    property p_hold;
        @(posedge clk) disable iff (!rstn)
        !upb_we |=> $stable(user_flash_base_address);
    endproperty
    a_hold: assert property (p_hold) else $error("base changed unasked"); // RULE5

    // Size writes leave the base alone
    property p_size_nowrite;
        @(posedge clk) disable iff (!rstn)
        wr_pend && hit_dram |=> $stable(user_flash_base_address);
    endproperty
    a_size_nowrite: assert property (p_size_nowrite) else $error("size write leaked"); // RULE7

    // Base read equals the base output
    property p_readback;
        @(posedge clk) disable iff (!rstn)
        rd_pend && hit_upb |-> hrdata == user_flash_base_address;
    endproperty
    a_readback: assert property (p_readback) else $error("base readback wrong"); // RULE2

    // Ready and OKAY from the edge after the first one out of reset
    property p_okay;
        @(posedge clk) disable iff (!rstn)
        rstn |=> hreadyout && !hresp;
    endproperty
    a_okay: assert property (p_okay) else $error("slave not ready"); // RULE1

    // Held reset clears the base and read data; two samples skip power-up
    property p_rst_zero;
        @(posedge clk)
        !rstn ##1 !rstn |-> user_flash_base_address == 32'h0000_0000 && hrdata == 32'h0000_0000;
    endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("reset left data"); // RULE5

    // Held reset keeps the slave not ready and OKAY
    property p_ready_reset;
        @(posedge clk)
        !rstn ##1 !rstn |-> !hreadyout && !hresp;
    endproperty
    a_ready_reset: assert property (p_ready_reset) else $error("ready in reset"); // RULE5

    // Base is zero on the first edge after release
    property p_base_release;
        @(posedge clk)
        !rstn ##1 rstn |-> user_flash_base_address == 32'h0000_0000;
    endproperty
    a_base_release: assert property (p_base_release) else $error("base not cleared"); // RULE5

    // Registered read path matches the captured decode
    property p_read_mux;
        @(posedge clk) disable iff (!rstn)
        rd_pend |-> hrdata == rd_word;
    endproperty
    a_read_mux: assert property (p_read_mux) else $error("read mux wrong"); // RULE1

    // No read data outside a read data phase
    property p_idle_zero;
        @(posedge clk) disable iff (!rstn)
        !rd_pend |-> hrdata == 32'h0000_0000;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("stale read data"); // RULE1

    // Unmapped offsets read zero
    property p_unmapped;
        @(posedge clk) disable iff (!rstn)
        rd_pend && !hit_dram && !hit_upb |-> hrdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read"); // RULE1

    // Size read is one of the three legal encodings
    property p_size_legal;
        @(posedge clk) disable iff (!rstn)
        rd_pend && hit_dram |->
            (hrdata == BMP_RAM_16K || hrdata == BMP_RAM_32K || hrdata == BMP_RAM_64K);
    endproperty
    a_size_legal: assert property (p_size_legal) else $error("size illegal"); // RULE1

    // Base output carries the stored field
    property p_field_track;
        @(posedge clk) disable iff (!rstn)
        1'b1 |-> user_flash_base_address[19:11] == upb_field;
    endproperty
    a_field_track: assert property (p_field_track) else $error("field mismatch"); // RULE2

    // Base read carries the stored field
    property p_upb_field_read;
        @(posedge clk) disable iff (!rstn)
        rd_pend && hit_upb |-> hrdata[19:11] == upb_field;
    endproperty
    a_upb_field_read: assert property (p_upb_field_read) else $error("field read wrong"); // RULE2

    // Any base change traces back to a base write
    property p_change_cause;
        @(posedge clk) disable iff (!rstn)
        $changed(user_flash_base_address) |-> $past(upb_we);
    endproperty
    a_change_cause: assert property (p_change_cause) else $error("base changed alone"); // RULE2

    // Top bits of the base output stay zero
    property p_high_ufb;
        @(posedge clk) disable iff (!rstn)
        1'b1 |-> user_flash_base_address[31:20] == 12'h000;
    endproperty
    a_high_ufb: assert property (p_high_ufb) else $error("base high set"); // RULE4

    // Low bits of a base read stay zero
    property p_upb_low_read;
        @(posedge clk) disable iff (!rstn)
        rd_pend && hit_upb |-> hrdata[10:0] == 11'h000;
    endproperty
    a_upb_low_read: assert property (p_upb_low_read) else $error("read low set"); // RULE3

    // A base write keeps only the field, whatever else is written
    property p_write_mask;
        @(posedge clk) disable iff (!rstn)
        upb_we |=> user_flash_base_address == ($past(hwdata) & BMP_UPB_MASK);
    endproperty
    a_write_mask: assert property (p_write_mask) else $error("write mask wrong"); // RULE4

    // Writes elsewhere leave the base alone
    property p_other_nowrite;
        @(posedge clk) disable iff (!rstn)
        wr_pend && !hit_upb |=> $stable(user_flash_base_address);
    endproperty
    a_other_nowrite: assert property (p_other_nowrite) else $error("stray write"); // RULE7

    // Write data phase shows no read data
    property p_write_no_data;
        @(posedge clk) disable iff (!rstn)
        wr_pend |-> hrdata == 32'h0000_0000;
    endproperty
    a_write_no_data: assert property (p_write_no_data) else $error("data on write"); // RULE7
endmodule

// [dv/tb_bus_matrix_memory_partition_regs.sv]
module tb_bus_matrix_memory_partition_regs import bmp_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rstn = 0, hsel = 0, hwrite = 0, act = 0, hready, hresp;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, ufb, seed = 32'h9267;
    logic [31:0] q[$];
    int error_cnt = 0, n_compared = 0;
    // Non-default size proves the parameter reaches the read path
    bmp_regs #(.RAM_SIZE(BMP_RAM_32K)) uut (.clk(clk), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .user_flash_base_address(ufb));
    // 40 MHz clock
    initial forever #12.5 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One single transfer; waits on hready, never on a fixed count
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= BMP_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        hsize <= BMP_HSIZE_WORD;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        act <= !w;
        do @(posedge clk); while (hready !== 1'b1);
        act <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        q.push_back(e);
        xfer(1'b0, a, ~e);
    endtask
    // Read data is only valid at the data-phase edge
    always @(posedge clk) if (act) chk(hrdata, q.pop_front());
    always @(posedge clk) if (act) chk({31'h0, hresp}, 32'h0);
    task automatic wrap_up();
        $display("errors %0d compared %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Main sequence, including a reset in mid-run
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk(ufb, 32'h0);
        rd(BMP_OFF_DRAM_SIZE, BMP_RAM_32K);
        xfer(1'b1, BMP_OFF_DRAM_SIZE, 32'hFFFF_FFFF);
        rd(BMP_OFF_DRAM_SIZE, BMP_RAM_32K);
        xfer(1'b1, BMP_OFF_UPB, 32'hFFFF_FFFF);
        rd(BMP_OFF_UPB, BMP_UPB_MASK);
        xfer(1'b1, 32'h0000_0010, 32'h0);
        rd(32'h0000_0010, 32'h0);
        rd(BMP_OFF_UPB, BMP_UPB_MASK);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            xfer(1'b1, BMP_OFF_UPB, seed);
            rd(BMP_OFF_UPB, seed & BMP_UPB_MASK);
            chk(ufb, seed & BMP_UPB_MASK);
        end
        xfer(1'b1, BMP_OFF_UPB, BMP_UPB_MASK);
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(BMP_OFF_UPB, 32'h0);
        rd(BMP_OFF_DRAM_SIZE, BMP_RAM_32K);
        wrap_up();
    end
    // Watchdog well past the expected run length
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end
endmodule
